// ===== lqm_pkg.sv
// Notes on behaviour
// - Compare only when enabled and 100M link valid
// - Threshold at max or min disables comparison
// - Control bits 14:10 ignore writes, read zero
// - Bit 9 flags frequency control above high
// - Bit 8 flags frequency control below low
// - Bit 7 flags frequency offset above high
// - Bit 6 flags frequency offset below low
// - Bit 5 flags baseline wander above high
// - Bit 4 flags baseline wander below low
// - Bit 3 flags gain control above high
// - Bit 2 flags gain control below low
// - Bit 1 flags equalizer coefficient above high
// - Bit 0 flags equalizer coefficient below low
// - Warning flags read-only, cleared by reading
// - No threshold writes while powered down
// - Sample trigger captures selected parameter for reading
// - Write strobe stores value into selected threshold
// - Write strobe self-clears, always reads zero
// - Three-bit select picks parameter for both uses
// - Control read clears flags, re-arms interrupt
// - Interrupt only when monitor interrupt enabled
`default_nettype none

package lqm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0]  CTRL_ADDR        = 5'h1D;
  localparam logic [4:0]  DATA_ADDR        = 5'h1E;
  localparam int          CTRL_ENABLE_BIT  = 15;
  localparam int          FLAG_W           = 10;
  localparam int          DATA_SAMPLE_BIT  = 13;
  localparam int          DATA_STROBE_BIT  = 12;
  localparam int          SEL_LSB          = 9;
  localparam int          SEL_W            = 3;
  localparam int          THR_SEL_BIT      = 8;
  localparam int          THR_VAL_W        = 8;
  localparam logic        CTRL_ENABLE_RST  = 1'b0;
  localparam logic [9:0]  FLAGS_RST        = 10'h000;
  localparam logic [15:0] RDATA_RST        = 16'h0000;

  // ****************************************************************
  // Parameters and thresholds
  // ****************************************************************
  localparam int          NUM_PARAMS       = 5;
  localparam int          NUM_THR          = 10;
  localparam logic [2:0]  PSEL_EQ_COEF     = 3'h0;
  localparam logic [2:0]  PSEL_GAIN        = 3'h1;
  localparam logic [2:0]  PSEL_WANDER      = 3'h2;
  localparam logic [2:0]  PSEL_OFFSET      = 3'h3;
  localparam logic [2:0]  PSEL_FREQ_CTRL   = 3'h4;
  localparam logic [7:0]  THR_MAX          = 8'hFF;
  localparam logic [7:0]  THR_MIN          = 8'h00;
  localparam logic [7:0]  THR_HIGH_RST     = 8'hFF;
  localparam logic [7:0]  THR_LOW_RST      = 8'h00;

  typedef logic [THR_VAL_W-1:0] param_val_t;
  typedef logic [3:0]           thr_idx_t;
  typedef logic [SEL_W-1:0]     param_sel_t;

  // Low threshold of parameter p sits at 2p, high at 2p+1
  function automatic thr_idx_t thr_index(input param_sel_t sel, input logic high);
    return {sel, high};
  endfunction : thr_index

  function automatic logic param_valid(input param_sel_t sel);
    return (sel <= PSEL_FREQ_CTRL);
  endfunction : param_valid

endpackage : lqm_pkg

`default_nettype wire

// ===== lqm_thr_if.sv
`default_nettype none

interface lqm_thr_if;
  import lqm_pkg::*;

  logic       wr_en;
  thr_idx_t   wr_idx;
  param_val_t wr_data;
  param_val_t thr [NUM_THR];

  modport store (input wr_en, input wr_idx, input wr_data, output thr);
  modport user  (output wr_en, output wr_idx, output wr_data, input thr);
endinterface : lqm_thr_if

`default_nettype wire

// ===== lqm_threshold_store.sv
`default_nettype none

module lqm_threshold_store
  import lqm_pkg::*;
(
  input  wire logic    i_clk_sys,
  input  wire logic    i_sys_rst,
  lqm_thr_if.store     bus
);

  // ****************************************************************
  // Threshold array, comparisons start disabled
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_THR; i++) begin
        bus.thr[i] <= (i % 2 == 1) ? THR_HIGH_RST : THR_LOW_RST;
      end
    end else if (bus.wr_en && (bus.wr_idx < thr_idx_t'(NUM_THR))) begin
      bus.thr[bus.wr_idx] <= bus.wr_data;
    end
  end

endmodule : lqm_threshold_store

`default_nettype wire

// ===== lqm_compare.sv
`default_nettype none

module lqm_compare
  import lqm_pkg::*;
(
  input  wire logic       i_active,
  input  wire param_val_t i_value,
  input  wire param_val_t i_high,
  input  wire param_val_t i_low,
  output logic            o_high_viol,
  output logic            o_low_viol
);

  // Extremes can never be exceeded, so they switch a check off
  assign o_high_viol = i_active && (i_high != THR_MAX) && (i_value > i_high);
  assign o_low_viol  = i_active && (i_low != THR_MIN) && (i_value < i_low);

endmodule : lqm_compare

`default_nettype wire

// ===== link_quality_monitor_regs.sv
`default_nettype none

module link_quality_monitor_regs
  import lqm_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic [4:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  input  wire logic        i_link_100_ok,
  input  wire logic        i_power_down,
  input  wire logic        i_irq_enable,
  input  wire param_val_t  i_equalizer_first_coef,
  input  wire param_val_t  i_digital_gain_ctrl,
  input  wire param_val_t  i_digital_wander_comp,
  input  wire param_val_t  i_freq_offset,
  input  wire param_val_t  i_freq_ctrl,
  output logic             o_quality_irq,
  output logic             o_monitor_active
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic              ctrl_wr;
  logic              ctrl_rd;
  logic              data_wr;
  logic              data_rd;
  param_sel_t        wr_sel;
  logic              active;
  logic              monitor_enable;
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] viol;
  logic [FLAG_W-1:0] next_flags;
  logic              new_flag;
  logic              irq_armed;
  logic              sample_trigger;
  param_sel_t        quality_param_select;
  logic              threshold_select;
  param_val_t        sample_val;
  param_val_t        values [NUM_PARAMS];
  param_val_t        thr_readback;
  logic [15:0]       next_rdata;

  lqm_thr_if thr_bus ();

  assign ctrl_wr = i_reg_wr && (i_reg_addr == CTRL_ADDR);
  assign ctrl_rd = i_reg_rd && (i_reg_addr == CTRL_ADDR);
  assign data_wr = i_reg_wr && (i_reg_addr == DATA_ADDR);
  assign data_rd = i_reg_rd && (i_reg_addr == DATA_ADDR);
  assign wr_sel  = i_reg_wdata[SEL_LSB +: SEL_W];
  assign active  = monitor_enable && i_link_100_ok;

  assign values[PSEL_EQ_COEF]   = i_equalizer_first_coef;
  assign values[PSEL_GAIN]      = i_digital_gain_ctrl;
  assign values[PSEL_WANDER]    = i_digital_wander_comp;
  assign values[PSEL_OFFSET]    = i_freq_offset;
  assign values[PSEL_FREQ_CTRL] = i_freq_ctrl;

  // ****************************************************************
  // Control register: enable only, reserved bits not stored
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      monitor_enable <= CTRL_ENABLE_RST;
    end else if (ctrl_wr) begin
      monitor_enable <= i_reg_wdata[CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_monitor_active <= 1'b0;
    end else begin
      o_monitor_active <= active;
    end
  end

  // ****************************************************************
  // Data register fields
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sample_trigger       <= 1'b0;
      quality_param_select <= PSEL_EQ_COEF;
      threshold_select     <= 1'b0;
    end else if (data_wr) begin
      sample_trigger       <= i_reg_wdata[DATA_SAMPLE_BIT];
      quality_param_select <= wr_sel;
      threshold_select     <= i_reg_wdata[THR_SEL_BIT];
    end
  end

  // Snapshot keeps the value steady while software reads it back
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sample_val <= THR_MIN;
    end else if (data_wr && i_reg_wdata[DATA_SAMPLE_BIT]) begin
      sample_val <= param_valid(wr_sel) ? values[wr_sel] : THR_MIN;
    end
  end

  // Strobe is never stored, so it cannot read back as one
  assign thr_bus.wr_en   = data_wr && i_reg_wdata[DATA_STROBE_BIT]
                           && !i_power_down && param_valid(wr_sel);
  assign thr_bus.wr_idx  = thr_index(wr_sel, i_reg_wdata[THR_SEL_BIT]);
  assign thr_bus.wr_data = i_reg_wdata[THR_VAL_W-1:0];

  lqm_threshold_store u_store (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .bus       (thr_bus.store)
  );

  // ****************************************************************
  // Comparators, flag bit 2p+1 high and 2p low for parameter p
  // ****************************************************************
  for (genvar p = 0; p < NUM_PARAMS; p++) begin : g_cmp
    lqm_compare u_cmp (
      .i_active    (active),
      .i_value     (values[p]),
      .i_high      (thr_bus.thr[2*p+1]),
      .i_low       (thr_bus.thr[2*p]),
      .o_high_viol (viol[2*p+1]),
      .o_low_viol  (viol[2*p])
    );
  end

  // ****************************************************************
  // Sticky flags, a new violation beats the read clear
  // ****************************************************************
  assign next_flags = (flags & ~{FLAG_W{ctrl_rd}}) | viol;
  assign new_flag   = |(viol & ~flags);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      flags <= FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // One request per arming; a control read re-arms it
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      irq_armed     <= 1'b1;
      o_quality_irq <= 1'b0;
    end else if (new_flag && irq_armed && i_irq_enable) begin
      irq_armed     <= 1'b0;
      o_quality_irq <= 1'b1;
    end else if (ctrl_rd) begin
      irq_armed     <= 1'b1;
      o_quality_irq <= 1'b0;
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  always_comb begin
    thr_readback = THR_MIN;
    if (param_valid(quality_param_select)) begin
      thr_readback = thr_bus.thr[thr_index(quality_param_select, threshold_select)];
    end
    next_rdata = RDATA_RST;
    if (ctrl_rd) begin
      next_rdata[CTRL_ENABLE_BIT]  = monitor_enable;
      next_rdata[FLAG_W-1:0]       = flags;
    end else if (data_rd) begin
      next_rdata[DATA_SAMPLE_BIT]       = sample_trigger;
      next_rdata[SEL_LSB +: SEL_W]      = quality_param_select;
      next_rdata[THR_SEL_BIT]           = threshold_select;
      next_rdata[THR_VAL_W-1:0]         = sample_trigger ? sample_val : thr_readback;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_reg_rdata <= RDATA_RST;
    end else if (i_reg_rd) begin
      o_reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_ctrl_read;
    ctrl_rd;
  endsequence

  sequence s_quiet_read;
    ctrl_rd && !active;
  endsequence

  sequence s_thr_write;
    data_wr && i_reg_wdata[DATA_STROBE_BIT] && param_valid(wr_sel) && !i_power_down;
  endsequence

  sequence s_sample_write;
    data_wr && i_reg_wdata[DATA_SAMPLE_BIT];
  endsequence

  sequence s_data_read;
    data_rd;
  endsequence

  chk_flags_stay_set: assert property (!ctrl_rd |=> ((flags & $past(flags)) == $past(flags)))
    else $error("warning flag dropped without a read");

  chk_idle_no_flags: assert property (!active |=> ((flags & ~$past(flags)) == FLAGS_RST))
    else $error("flag set while monitor inactive");

  chk_read_clears: assert property (s_quiet_read |=> (flags == FLAGS_RST))
    else $error("control read did not clear flags");

  chk_read_returns_flags: assert property (s_ctrl_read |=>
      (o_reg_rdata[FLAG_W-1:0] == $past(flags)) && (o_reg_rdata[14:10] == 5'h00))
    else $error("control readback wrong");

  chk_strobe_reads_zero: assert property (i_reg_rd |=> !o_reg_rdata[DATA_STROBE_BIT])
    else $error("write strobe read back as one");

  chk_powerdown_hold: assert property (data_wr && i_power_down |=>
      (thr_bus.thr[thr_index(PSEL_FREQ_CTRL, 1'b1)] == $past(thr_bus.thr[thr_index(PSEL_FREQ_CTRL, 1'b1)]))
      && (thr_bus.thr[thr_index(PSEL_EQ_COEF, 1'b0)] == $past(thr_bus.thr[thr_index(PSEL_EQ_COEF, 1'b0)])))
    else $error("threshold changed while powered down");

  chk_thr_stored: assert property (s_thr_write |=>
      (thr_bus.thr[$past(thr_bus.wr_idx)] == $past(i_reg_wdata[THR_VAL_W-1:0])))
    else $error("threshold write not stored");

  chk_sample_load: assert property (data_wr && i_reg_wdata[DATA_SAMPLE_BIT] && param_valid(wr_sel) |=>
      (sample_val == $past(values[wr_sel])))
    else $error("sampled value wrong");

  chk_max_disables: assert property ((thr_bus.thr[9] == THR_MAX) |-> !viol[9])
    else $error("disabled high threshold raised a warning");

  chk_freq_ctrl_high: assert property (active && (thr_bus.thr[9] != THR_MAX)
      && (i_freq_ctrl > thr_bus.thr[9]) |=> flags[9])
    else $error("frequency control high warning missed");

  chk_gain_low: assert property (active && (thr_bus.thr[2] != THR_MIN)
      && (i_digital_gain_ctrl < thr_bus.thr[2]) |=> flags[2])
    else $error("gain low warning missed");

  chk_irq_gated: assert property ($rose(o_quality_irq) |-> $past(i_irq_enable) && $past(irq_armed))
    else $error("interrupt raised while not enabled");

  chk_irq_rearm: assert property (s_ctrl_read ##0 !(new_flag && irq_armed && i_irq_enable)
      |=> irq_armed && !o_quality_irq)
    else $error("control read did not re-arm interrupt");

  // ****************************************************************
  // Per-flag, readback and interrupt hold checks
  // ****************************************************************
  chk_freq_ctrl_low: assert property (active && (thr_bus.thr[8] != THR_MIN)
      && (i_freq_ctrl < thr_bus.thr[8]) |=> flags[8])
    else $error("frequency control low warning missed");

  chk_offset_high: assert property (active && (thr_bus.thr[7] != THR_MAX)
      && (i_freq_offset > thr_bus.thr[7]) |=> flags[7])
    else $error("frequency offset high warning missed");

  chk_offset_low: assert property (active && (thr_bus.thr[6] != THR_MIN)
      && (i_freq_offset < thr_bus.thr[6]) |=> flags[6])
    else $error("frequency offset low warning missed");

  chk_wander_high: assert property (active && (thr_bus.thr[5] != THR_MAX)
      && (i_digital_wander_comp > thr_bus.thr[5]) |=> flags[5])
    else $error("wander high warning missed");

  chk_wander_low: assert property (active && (thr_bus.thr[4] != THR_MIN)
      && (i_digital_wander_comp < thr_bus.thr[4]) |=> flags[4])
    else $error("wander low warning missed");

  chk_gain_high: assert property (active && (thr_bus.thr[3] != THR_MAX)
      && (i_digital_gain_ctrl > thr_bus.thr[3]) |=> flags[3])
    else $error("gain high warning missed");

  chk_coef_high: assert property (active && (thr_bus.thr[1] != THR_MAX)
      && (i_equalizer_first_coef > thr_bus.thr[1]) |=> flags[1])
    else $error("coefficient high warning missed");

  chk_coef_low: assert property (active && (thr_bus.thr[0] != THR_MIN)
      && (i_equalizer_first_coef < thr_bus.thr[0]) |=> flags[0])
    else $error("coefficient low warning missed");

  chk_min_disables: assert property ((thr_bus.thr[0] == THR_MIN) |-> !viol[0])
    else $error("disabled low threshold raised a warning");

  // A violation in the read cycle must survive the clear
  chk_viol_sets_flag: assert property (|viol |=> ((flags & $past(viol)) == $past(viol)))
    else $error("violation did not set its flag");

  chk_enable_write: assert property (ctrl_wr |=>
      (monitor_enable == $past(i_reg_wdata[CTRL_ENABLE_BIT])))
    else $error("monitor enable not written");

  chk_active_copy: assert property (1'b1 |=> (o_monitor_active == $past(active)))
    else $error("monitor active output wrong");

  chk_data_readback: assert property (s_data_read |=>
      (o_reg_rdata[SEL_LSB +: SEL_W] == $past(quality_param_select)) && (o_reg_rdata[15:14] == 2'h0))
    else $error("data register fields read back wrong");

  chk_sample_readback: assert property (s_data_read ##0 sample_trigger |=>
      (o_reg_rdata[THR_VAL_W-1:0] == $past(sample_val)))
    else $error("sampled value not returned");

  chk_thr_readback: assert property (s_data_read ##0 (!sample_trigger && param_valid(quality_param_select))
      |=> (o_reg_rdata[THR_VAL_W-1:0]
           == $past(thr_bus.thr[thr_index(quality_param_select, threshold_select)])))
    else $error("threshold not returned");

  chk_sample_invalid: assert property (s_sample_write ##0 !param_valid(wr_sel) |=>
      (sample_val == THR_MIN))
    else $error("unmapped select sampled a value");

  chk_strobe_invalid: assert property (data_wr && i_reg_wdata[DATA_STROBE_BIT] && !param_valid(wr_sel)
      |-> !thr_bus.wr_en)
    else $error("unmapped select wrote a threshold");

  chk_powerdown_target: assert property (data_wr && i_power_down && param_valid(wr_sel) |=>
      (thr_bus.thr[$past(thr_bus.wr_idx)] == $past(thr_bus.thr[thr_bus.wr_idx])))
    else $error("addressed threshold changed while powered down");

  chk_irq_needs_flag: assert property ($rose(o_quality_irq) |-> $past(new_flag))
    else $error("interrupt raised without a new warning");

  chk_irq_holds: assert property (o_quality_irq && !ctrl_rd |=> o_quality_irq)
    else $error("interrupt dropped without a control read");

endmodule : link_quality_monitor_regs

`default_nettype wire

// ===== link_quality_monitor_regs_tb.sv
`default_nettype none

module link_quality_monitor_regs_tb
  import lqm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and model state
  // ****************************************************************
  logic        clk_sys = 1'b0;
  logic        sys_rst;
  logic [4:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        link_ok;
  logic        pwr_down;
  logic        irq_en;
  logic        quality_irq;
  logic        mon_active;
  param_val_t  val [NUM_PARAMS];
  int          thr [NUM_THR];
  int          bad_count;
  int          check_count;
  int          seed;
  int          en;
  int          sel;
  int          tsel;
  int          samp;
  int          snap;
  int          flags;
  int          t;
  int          ok;
  int          r;

  always #5 clk_sys = ~clk_sys;

  link_quality_monitor_regs u_link_quality_monitor_regs (
    .i_clk_sys              (clk_sys),
    .i_sys_rst              (sys_rst),
    .i_reg_addr             (reg_addr),
    .i_reg_wr               (reg_wr),
    .i_reg_rd               (reg_rd),
    .i_reg_wdata            (reg_wdata),
    .o_reg_rdata            (reg_rdata),
    .i_link_100_ok          (link_ok),
    .i_power_down           (pwr_down),
    .i_irq_enable           (irq_en),
    .i_equalizer_first_coef (val[0]),
    .i_digital_gain_ctrl    (val[1]),
    .i_digital_wander_comp  (val[2]),
    .i_freq_offset          (val[3]),
    .i_freq_ctrl            (val[4]),
    .o_quality_irq          (quality_irq),
    .o_monitor_active       (mon_active)
  );

  // ****************************************************************
  // Model, checks and bus tasks
  // ****************************************************************
  function automatic int rnd(input int n);
    return ($random(seed) & 32'h7FFFFFFF) % n;
  endfunction : rnd

  // Violations that the monitor sees with the current state
  function automatic int viol();
    int v;
    v = 0;
    for (int p = 0; p < NUM_PARAMS; p++) begin
      if (en && link_ok && thr[2*p+1] != 255 && val[p] > thr[2*p+1]) v |= 1 << (2*p+1);
      if (en && link_ok && thr[2*p] != 0 && val[p] < thr[2*p]) v |= 1 << (2*p);
    end
    return v;
  endfunction : viol

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: read data %h, expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: status output %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a == CTRL_ADDR) en = d[CTRL_ENABLE_BIT];
    if (a == DATA_ADDR) begin
      sel  = d[11:9];
      tsel = d[THR_SEL_BIT];
      samp = d[DATA_SAMPLE_BIT];
      if (samp && sel < NUM_PARAMS) snap = val[sel];
      if (d[DATA_STROBE_BIT] && !pwr_down && sel < NUM_PARAMS) thr[2*sel+tsel] = d[7:0];
    end
    @(posedge clk_sys);
    flags |= viol();
  endtask : wr

  task automatic rd(input logic [4:0] a);
    logic [15:0] e;
    flags |= viol();
    e = 16'h0000;
    if (a == CTRL_ADDR) e = {en[0], 5'h00, flags[9:0]};
    if (a == DATA_ADDR) e = {2'h0, samp[0], 1'h0, sel[2:0], tsel[0],
                             (samp ? snap[7:0] : (sel < NUM_PARAMS ? thr[2*sel+tsel][7:0] : 8'h00))};
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // A violation present during the read keeps its flag
    if (a == CTRL_ADDR) flags = viol();
    #1;
    chk_word(reg_rdata, e);
  endtask : rd

  task automatic setv(input int p, input int v);
    @(posedge clk_sys);
    val[p] <= v[7:0];
    repeat (2) @(posedge clk_sys);
    flags |= viol();
  endtask : setv

  task automatic finish_test();
    $display("Comparisons: %0d, mismatches: %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    #100000;
    bad_count++;
    $display("CHECK FAILED at %0t: run did not complete", $time);
    finish_test();
  end

  initial begin
    sys_rst = 1'b1;
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
    link_ok = 1'b1;
    pwr_down = 1'b0;
    irq_en = 1'b0;
    for (int p = 0; p < NUM_PARAMS; p++) val[p] = 8'h80;
    for (int i = 0; i < NUM_THR; i++) thr[i] = (i % 2) ? 255 : 0;
    seed = 32'h6195B48B;
    bad_count = 0;
    check_count = 0;
    en = 0; sel = 0; tsel = 0; samp = 0; snap = 0; flags = 0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(CTRL_ADDR);
    rd(DATA_ADDR);
    rd(5'h05);
    wr(CTRL_ADDR, 16'hFFFF);
    rd(CTRL_ADDR);
    chk_bit(mon_active, 1'b1);
    for (int p = 0; p < NUM_PARAMS; p++) begin
      for (int h = 0; h < 2; h++) begin
        t = 1 + rnd(254);
        ok = h ? 0 : 255;
        setv(p, ok);
        wr(DATA_ADDR, {4'h1, p[2:0], h[0], t[7:0]});
        rd(DATA_ADDR);
        rd(CTRL_ADDR);
        setv(p, h ? t + 1 + rnd(255 - t) : rnd(t));
        wr(DATA_ADDR, {4'h2, p[2:0], h[0], 8'h00});
        setv(p, ok);
        rd(DATA_ADDR);
        chk_bit(quality_irq, 1'b0);
        rd(CTRL_ADDR);
        rd(CTRL_ADDR);
        r = rnd(256);
        @(posedge clk_sys);
        pwr_down <= 1'b1;
        wr(DATA_ADDR, {4'h1, p[2:0], h[0], r[7:0]});
        @(posedge clk_sys);
        pwr_down <= 1'b0;
        rd(DATA_ADDR);
        wr(DATA_ADDR, {4'h1, p[2:0], h[0], h ? 8'hFF : 8'h00});
      end
    end
    r = 5 + rnd(3);
    wr(DATA_ADDR, {4'h1, r[2:0], 1'h1, 8'h33});
    rd(DATA_ADDR);
    // Monitor held off by a lost link, then by the enable bit
    wr(DATA_ADDR, 16'h1310);
    @(posedge clk_sys);
    link_ok <= 1'b0;
    setv(1, 200);
    chk_bit(mon_active, 1'b0);
    rd(CTRL_ADDR);
    setv(1, 0);
    wr(CTRL_ADDR, 16'h0000);
    @(posedge clk_sys);
    link_ok <= 1'b1;
    setv(1, 200);
    rd(CTRL_ADDR);
    chk_bit(mon_active, 1'b0);
    @(posedge clk_sys);
    irq_en <= 1'b1;
    wr(CTRL_ADDR, 16'h8000);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_bit(quality_irq, 1'b1);
    setv(1, 0);
    rd(CTRL_ADDR);
    @(posedge clk_sys);
    #1;
    chk_bit(quality_irq, 1'b0);
    finish_test();
  end

endmodule : link_quality_monitor_regs_tb

`default_nettype wire
